// ### verification/smbus_master_model.sv
`timescale 1ns/1ps
// ===============================================
// Bus master model: 160 ns bit, waits out stretch
// ===============================================
module smbus_master_model (
   input wire logic scl, // Clock line
   input wire logic sda, // Data line
   output logic scl_oe, // Master pulls clock low
   output logic sda_oe // Master pulls data low
);
   int stalls = 0; // Rises that never came
   // Lines released: pull-ups hold the bus idle
   initial begin
      scl_oe = 1'h0;
      sda_oe = 1'h0;
   end
   // Release clock, bounded wait on slave stretching
   task automatic rise;
      scl_oe = 1'h0;
      for (int n = 0; n < 400 && scl !== 1'h1; n++)
         #10;
      if (scl !== 1'h1)
         stalls++;
   endtask
   // Data set in low phase, sampled late in high phase
   task automatic bit_io(input logic d, output logic r);
      #40 sda_oe = !d;
      #60 rise();
      #50 r = sda;
      #10 scl_oe = 1'h1;
   endtask
   // MSB first; the caller sends the acknowledge bit
   task automatic xbyte(input logic [7:0] d, output logic [7:0] r);
      for (int i = 7; i >= 0; i--)
         bit_io(d[i], r[i]);
   endtask
   // Data falls while clock high
   task automatic start;
      #40 sda_oe = 1'h0;
      #60 rise();
      #60 sda_oe = 1'h1;
      #60 scl_oe = 1'h1;
   endtask
   // Data rises while clock high; clock then stands
   task automatic stop;
      #40 sda_oe = 1'h1;
      #60 rise();
      #60 sda_oe = 1'h0;
      #100;
   endtask
endmodule // smbus_master_model

// ### verification/smbus_slave_addr_match_bench.sv
`timescale 1ns/1ps
`include "smbus_slave_map.svh"
// ===============================================
// Bench: APB host plus bus master model
// ===============================================
module smbus_slave_addr_match_bench;
   logic clk, rst, psel, penable, pwrite, pready, pslverr, irq, b, er;
   logic scl_out, scl_oe, sda_out, sda_oe, m_scl_oe, m_sda_oe;
   logic [7:0] paddr, q;
   logic [31:0] pwdata, prdata, rd;
   int error_cnt = 0; // Mismatches
   int n_tests = 0; // Comparisons
   wire scl = !(scl_oe || m_scl_oe); // Pulled up
   wire sda = !(sda_oe || m_sda_oe); // Pulled up
   smbus_slave_addr_match uut (.clk, .rst, .paddr, .psel, .penable,
      .pwrite, .pwdata, .prdata, .pready, .pslverr, .scl_in(scl),
      .scl_out, .scl_oe, .sda_in(sda), .sda_out, .sda_oe, .irq);
   smbus_master_model m (.scl, .sda, .scl_oe(m_scl_oe),
      .sda_oe(m_sda_oe));
   initial begin
      clk = 1'h0;
      forever #10 clk = !clk;
   end
   // ===============================================
   // Shared tasks
   // ===============================================
   task automatic wrap_up;
      if (error_cnt == 0 && n_tests > 0)
         $display("verification passed");
      else
         $display("verification failed");
      $finish;
   endtask
   task automatic chk(string s, logic [31:0] e, logic [31:0] g);
      n_tests++;
      if (g !== e) begin
         error_cnt++;
         $display("BAD %s expected %h seen %h", s, e, g);
      end
   endtask
   // One transfer; no ready ends run
   task automatic apb(logic w, logic [7:0] a, logic [31:0] d);
      @(posedge clk);
      psel <= 1'h1;
      pwrite <= w;
      paddr <= a;
      pwdata <= d;
      @(posedge clk);
      penable <= 1'h1;
      for (int n = 0; n < 16 && pready !== 1'h1; n++)
         @(negedge clk);
      chk("pready", 1'h1, pready);
      if (pready !== 1'h1)
         wrap_up();
      rd = prdata;
      er = pslverr;
      @(posedge clk);
      psel <= 1'h0;
      penable <= 1'h0;
   endtask
   task automatic rchk(string s, logic [7:0] a, logic [31:0] k,
      logic [31:0] e);
      apb(1'h0, a, 32'h0);
      chk(s, e, rd & k);
   endtask
   // Bounded irq wait
   task automatic wirq;
      for (int n = 0; n < 200 && irq !== 1'h1; n++)
         @(posedge clk);
      chk("irq", 1'h1, irq);
      if (irq !== 1'h1)
         wrap_up();
   endtask
   // ===============================================
   // Scenarios
   // ===============================================
   task automatic t_reset;
      rchk("ctrl", `OFF_CTRL, 32'hFFFF_FFFF, 32'h0);
      rchk("mask", `OFF_MASK, 32'hFFFF_FFFF, 32'hFE);
      apb(1'h0, 8'h1C, 32'h0);
      chk("unmapped", 1'h1, er);
   endtask
   // Own address, mask, general call; interrupt masked
   task automatic t_match;
      logic [22:0] tb [6] = '{
         {7'h70, 7'h73, 1'h0, 7'h7C, 1'h1}, {7'h70, 7'h73, 1'h0, 7'h71, 1'h0},
         {7'h34, 7'h7E, 1'h1, 7'h35, 1'h1}, {7'h34, 7'h7E, 1'h1, 7'h00, 1'h1},
         {7'h34, 7'h7E, 1'h1, 7'h36, 1'h0}, {7'h34, 7'h7F, 1'h0, 7'h00, 1'h0}};
      logic [6:0] o, k, a;
      logic g, e;
      for (int i = 0; i < 6; i++) begin
         {o, k, g, a, e} = tb[i];
         apb(1'h1, `OFF_ADDR, {24'h00_0000, o, g});
         apb(1'h1, `OFF_MASK, {24'h00_0000, k, 1'h1});
         m.start();
         m.xbyte({a, 1'h0}, q);
         m.bit_io(1'h1, b);
         chk("addr ack", !e, b);
         m.stop();
         rchk("si", `OFF_ISTAT, 32'h1, {31'h0, e});
         chk("irq masked", 1'h0, irq);
         apb(1'h1, `OFF_ISTAT, 32'h7);
         apb(1'h1, `OFF_CTRL, 32'h0);
      end
   endtask
   // Read: address, two bytes, master NACK, late write, STOP
   task automatic t_read;
      apb(1'h1, `OFF_ADDR, 32'h68);
      apb(1'h1, `OFF_MASK, 32'hFF);
      apb(1'h1, `OFF_IMASK, 32'h7);
      m.start();
      m.xbyte(8'h69, q);
      m.bit_io(1'h1, b);
      chk("addr ack", 1'h0, b);
      wirq();
      rchk("status", `OFF_CTRL, 32'hF0, 32'h60);
      apb(1'h1, `OFF_DATA, 32'hA5);
      apb(1'h1, `OFF_ISTAT, 32'h7);
      apb(1'h1, `OFF_CTRL, 32'h0);
      chk("irq clear", 1'h0, irq);
      m.xbyte(8'hFF, q);
      chk("byte 0", 32'hA5, q);
      repeat (6) @(posedge clk);
      chk("early si", 1'h0, irq);
      m.bit_io(1'h0, b);
      wirq();
      apb(1'h1, `OFF_DATA, 32'h3C);
      apb(1'h1, `OFF_ISTAT, 32'h7);
      apb(1'h1, `OFF_CTRL, 32'h0);
      m.xbyte(8'hFF, q);
      chk("byte 1", 32'h3C, q);
      m.bit_io(1'h1, b);
      wirq();
      apb(1'h1, `OFF_DATA, 32'hAA);
      rchk("error", `OFF_ISTAT, 32'h4, 32'h4);
      apb(1'h1, `OFF_ISTAT, 32'h7);
      apb(1'h1, `OFF_CTRL, 32'h0);
      m.stop();
      rchk("stopped", `OFF_CTRL, 32'hF0, 32'h10);
   endtask
   // Software answers the address; then slave inhibit
   task automatic t_soft;
      apb(1'h1, `OFF_MASK, 32'hFE);
      apb(1'h1, `OFF_ISTAT, 32'h7);
      m.start();
      m.xbyte(8'h69, q);
      wirq();
      rchk("ack req", `OFF_CTRL, 32'h8, 32'h8);
      apb(1'h1, `OFF_ISTAT, 32'h7);
      apb(1'h1, `OFF_CTRL, 32'h0);
      m.bit_io(1'h1, b);
      chk("sw nack", 1'h1, b);
      m.xbyte(8'h69, q);
      m.bit_io(1'h1, b);
      chk("silent ack", 1'h1, b);
      rchk("silent si", `OFF_ISTAT, 32'h1, 32'h0);
      m.stop();
      apb(1'h1, `OFF_CFG, 32'h1);
      apb(1'h1, `OFF_MASK, 32'hFF);
      m.start();
      m.xbyte(8'h68, q);
      m.bit_io(1'h1, b);
      chk("inhibit", 1'h1, b);
      m.stop();
   endtask
   initial begin
      rst = 1'h1;
      psel = 1'h0;
      penable = 1'h0;
      pwrite = 1'h0;
      paddr = 8'h0;
      pwdata = 32'h0;
      repeat (8) @(posedge clk);
      rst <= 1'h0;
      t_reset();
      t_match();
      t_read();
      t_soft();
      chk("stalls", 32'h0, m.stalls);
      wrap_up();
   end
endmodule // smbus_slave_addr_match_bench
bind smbus_slave_addr_match smbus_slave_addr_match_monitor mon (.clk, .rst,
   .psel, .penable, .pwrite, .prdata, .pready, .pslverr, .scl_in,
   .scl_out, .scl_oe, .sda_out, .sda_oe);

// ### verification/smbus_slave_addr_match_monitor.sv
`timescale 1ns/1ps
// ===============================================
// Port checks for the slave block
// ===============================================
module smbus_slave_addr_match_monitor (
   input wire logic clk, // Clock
   input wire logic rst, // Reset
   input wire logic psel, // Select
   input wire logic penable, // Enable
   input wire logic pwrite, // Write
   input wire logic [31:0] prdata, // Read data
   input wire logic pready, // Ready
   input wire logic pslverr, // Error
   input wire logic scl_in, // Clock line
   input wire logic scl_out, // Clock value
   input wire logic scl_oe, // Clock pull
   input wire logic sda_out, // Data value
   input wire logic sda_oe // Data pull
);
   default clocking cb @(posedge clk);
   endclocking
   default disable iff (rst);
   // Exactly one wait state, then a one-cycle ready
   property p_rdy_wait; psel && $rose(penable) |-> !pready ##1 pready ##1 !pready; endproperty
   a_rdy_wait: assert property (p_rdy_wait)
      else $error("ready timing wrong");
   property p_err_rdy; pslverr |-> pready && psel && penable; endproperty
   a_err_rdy: assert property (p_err_rdy)
      else $error("error without ready");
   // Read data only moves with a completed read
   property p_rd_hold; $changed(prdata) |-> pready && !pwrite; endproperty
   a_rd_hold: assert property (p_rd_hold)
      else $error("read data moved");
   property p_err_zero; pready && pslverr && !pwrite |-> prdata == 0; endproperty
   a_err_zero: assert property (p_err_zero)
      else $error("refused read not zero");
   // Open drain: only ever pulls low
   property p_pins_low; scl_oe || sda_oe |-> !scl_out && !sda_out; endproperty
   a_pins_low: assert property (p_pins_low)
      else $error("pin driven high");
   property p_sda_steady; scl_in && $past(scl_in) |-> $stable(sda_oe); endproperty
   a_sda_steady: assert property (p_sda_steady)
      else $error("data moved with clock high");
   property p_stretch_low; $rose(scl_oe) |-> !scl_in; endproperty
   a_stretch_low: assert property (p_stretch_low)
      else $error("stretch began with clock high");
   property p_ack_end; $fell(sda_oe) |-> !scl_in; endproperty
   a_ack_end: assert property (p_ack_end)
      else $error("data released with clock high");
endmodule // smbus_slave_addr_match_monitor

// ### verilog/smbus_slave_addr_match.sv
`timescale 1ns/1ps
`include "smbus_slave_map.svh"

module smbus_slave_addr_match (
   input wire logic clk, // System clock
   input wire logic rst, // Async reset, high
   input wire logic [7:0] paddr, // APB address
   input wire logic psel, // APB select
   input wire logic penable, // APB enable
   input wire logic pwrite, // APB write
   input wire logic [31:0] pwdata, // APB write data
   output logic [31:0] prdata, // APB read data
   output logic pready, // APB ready
   output logic pslverr, // APB error
   input wire logic scl_in, // Bus clock level
   output logic scl_out, // Bus clock drive value
   output logic scl_oe, // Bus clock pulled low
   input wire logic sda_in, // Bus data level
   output logic sda_out, // Bus data drive value
   output logic sda_oe, // Bus data pulled low
   output logic irq // Interrupt, level
);

   // =====================================================
   // Declarations
   // =====================================================
   logic scl_m_reg, scl_s_reg, scl_d_reg; // Clock sync
   logic sda_m_reg, sda_s_reg, sda_d_reg; // Data sync
   logic scl_rise, scl_fall, start_det, stop_det; // Bus events
   smbus_slave_pkg::slave_state_e state_reg; // Engine state
   logic [3:0] bit_cnt_reg; // Bits of current byte
   logic [7:0] shift_reg; // Serial shifter
   logic is_read_reg; // Direction of transfer
   logic addr_phase_reg; // Address received, ACK pending
   logic got_nack_reg; // Master answered NACK
   logic si_set_reg; // Interrupt raise pulse
   logic ack_request_flag_set_reg; // Ack request raise pulse
   logic tx_take_reg; // Data byte consumed
   logic [6:0] own_addr_reg; // own_slave_address
   logic gc_en_reg; // general_call_enable
   logic [6:0] mask_reg; // slave_address_mask
   logic hw_ack_reg; // hw_ack_enable
   logic inhibit_reg; // slave_inhibit
   logic ack_out_reg; // Software ACK choice
   logic si_reg; // Pending slave interrupt
   logic ack_request_flag_reg; // ack_request_flag
   logic start_flag_reg; // start_flag
   logic stop_flag_reg; // stop_flag
   logic [7:0] tx_data_reg; // Byte to transmit
   logic [7:0] rx_data_reg; // Last received byte
   logic tx_written_reg; // Data loaded since event
   logic [2:0] int_stat_reg; // Sticky event bits
   logic [2:0] int_mask_reg; // Event enables
   logic [2:0] events; // Event pulses
   logic wr_en, rd_en; // Completing write; read in wait state
   logic sw_si_clear; // Software releases engine
   logic tx_role; // Transmitter side active
   logic [31:0] rd_mux; // Read data select
   logic addr_hit; // Mapped address

   // =====================================================
   // Helpers
   // =====================================================
   // Masked own-address or general call comparison
   function automatic logic addr_match(input logic [6:0] a,
      input logic [6:0] own, input logic [6:0] msk,
      input logic gc);
      logic own_ok;
      own_ok = (((a ^ own) & msk) == 7'h00); // RL2 RL3
      addr_match = own_ok || (gc && (a == `GC_ADDR)); // RL4
   endfunction

   // True in any transmitter-side state
   function automatic logic is_tx(
      input smbus_slave_pkg::slave_state_e s);
      is_tx = (s == smbus_slave_pkg::st_tx) ||
         (s == smbus_slave_pkg::st_txack) ||
         (s == smbus_slave_pkg::st_txwait);
   endfunction

   // =====================================================
   // Pin synchronisers and bus event detect
   // =====================================================
   // Two stages, then a third for edge detection
   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         scl_m_reg <= 1'b1;
         scl_s_reg <= 1'b1;
         scl_d_reg <= 1'b1;
         sda_m_reg <= 1'b1;
         sda_s_reg <= 1'b1;
         sda_d_reg <= 1'b1;
      end else begin
         scl_m_reg <= scl_in;
         scl_s_reg <= scl_m_reg;
         scl_d_reg <= scl_s_reg;
         sda_m_reg <= sda_in;
         sda_s_reg <= sda_m_reg;
         sda_d_reg <= sda_s_reg;
      end
   end

   assign scl_rise = scl_s_reg && !scl_d_reg;
   assign scl_fall = !scl_s_reg && scl_d_reg;
   // Data moves while clock high: START or STOP
   assign start_det = scl_s_reg && scl_d_reg && !sda_s_reg
      && sda_d_reg;
   assign stop_det = scl_s_reg && scl_d_reg && sda_s_reg
      && !sda_d_reg;

   // =====================================================
   // APB strobes
   // =====================================================
   assign wr_en = psel && penable && pready && pwrite;
   assign rd_en = psel && penable && !pready && !pwrite;
   assign sw_si_clear = wr_en && (paddr == `OFF_CTRL)
      && !pwdata[`CTRL_SI];
   assign tx_role = is_tx(state_reg);

   // =====================================================
   // Slave engine
   // =====================================================
   // Bit engine; drives data line and raises events
   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         state_reg <= smbus_slave_pkg::st_idle;
         bit_cnt_reg <= `CNT_ZERO;
         shift_reg <= `RST_DATA;
         is_read_reg <= 1'b0;
         addr_phase_reg <= 1'b0;
         got_nack_reg <= 1'b0;
         si_set_reg <= 1'b0;
         ack_request_flag_set_reg <= 1'b0;
         tx_take_reg <= 1'b0;
         rx_data_reg <= `RST_DATA;
         sda_oe <= 1'b0;
      end else begin
         si_set_reg <= 1'b0;
         ack_request_flag_set_reg <= 1'b0;
         tx_take_reg <= 1'b0;
         if (start_det) begin
            // A new START re-arms the slave unless slave_inhibit is set
            sda_oe <= 1'b0;
            bit_cnt_reg <= `CNT_ZERO;
            if (inhibit_reg) begin
               state_reg <= smbus_slave_pkg::st_idle;
            end else begin
               state_reg <= smbus_slave_pkg::st_addr; // RL6 RL9
            end
         end else if (stop_det) begin
            sda_oe <= 1'b0;
            state_reg <= smbus_slave_pkg::st_idle; // RL12
         end else begin
            unique case (state_reg)
               smbus_slave_pkg::st_idle,
               smbus_slave_pkg::st_ignore: begin
                  // Silent; only START leaves
                  sda_oe <= 1'b0;
               end
               smbus_slave_pkg::st_addr,
               smbus_slave_pkg::st_rx: begin
                  if (scl_rise) begin
                     shift_reg <= {shift_reg[6:0], sda_s_reg};
                     bit_cnt_reg <= bit_cnt_reg + `CNT_ONE;
                  end else if (scl_fall &&
                        bit_cnt_reg == `CNT_BYTE) begin
                     bit_cnt_reg <= `CNT_ZERO;
                     if (state_reg == smbus_slave_pkg::st_addr) begin
                        is_read_reg <= shift_reg[0]; // RL16
                        addr_phase_reg <= 1'b1; // RL5
                     end else begin
                        rx_data_reg <= shift_reg;
                     end
                     if (hw_ack_reg) begin
                        // Match in address phase, any data byte
                        if (state_reg == smbus_slave_pkg::st_rx ||
                              addr_match(shift_reg[7:1], own_addr_reg,
                              mask_reg, gc_en_reg)) begin // RL16
                           sda_oe <= 1'b1; // RL1 RL8
                           state_reg <= smbus_slave_pkg::st_ack;
                        end else begin
                           state_reg <= smbus_slave_pkg::st_ignore; // RL9
                        end
                     end else begin
                        si_set_reg <= 1'b1; // RL7
                        ack_request_flag_set_reg <= 1'b1; // RL7
                        state_reg <= smbus_slave_pkg::st_wait;
                     end
                  end
               end
               smbus_slave_pkg::st_wait: begin
                  // Clock is stretched until software answers
                  if (sw_si_clear) begin
                     if (pwdata[`CTRL_ACK]) begin
                        sda_oe <= 1'b1; // RL7
                        state_reg <= smbus_slave_pkg::st_ack;
                     end else begin
                        state_reg <= smbus_slave_pkg::st_ignore; // RL9
                     end
                  end
               end
               smbus_slave_pkg::st_ack: begin
                  if (scl_fall) begin
                     addr_phase_reg <= 1'b0;
                     bit_cnt_reg <= `CNT_ZERO;
                     if (is_read_reg && tx_written_reg) begin
                        // Byte already loaded: start sending
                        shift_reg <= tx_data_reg;
                        sda_oe <= !tx_data_reg[7];
                        tx_take_reg <= 1'b1;
                        state_reg <= smbus_slave_pkg::st_tx; // RL10
                     end else if (is_read_reg) begin
                        sda_oe <= 1'b0;
                        si_set_reg <= 1'b1; // RL8
                        state_reg <= smbus_slave_pkg::st_txwait;
                     end else begin
                        sda_oe <= 1'b0;
                        si_set_reg <= hw_ack_reg; // RL8
                        state_reg <= smbus_slave_pkg::st_rx;
                     end
                  end
               end
               smbus_slave_pkg::st_tx: begin
                  if (scl_fall) begin
                     bit_cnt_reg <= bit_cnt_reg + `CNT_ONE;
                     if (bit_cnt_reg == `CNT_LAST) begin
                        sda_oe <= 1'b0; // Free line for master ACK
                        state_reg <= smbus_slave_pkg::st_txack;
                     end else begin
                        shift_reg <= {shift_reg[6:0], 1'b0};
                        sda_oe <= !shift_reg[6];
                     end
                  end
               end
               smbus_slave_pkg::st_txack: begin
                  if (scl_rise) begin
                     got_nack_reg <= sda_s_reg;
                  end else if (scl_fall) begin
                     si_set_reg <= 1'b1; // RL14
                     state_reg <= smbus_slave_pkg::st_txwait;
                  end
               end
               smbus_slave_pkg::st_txwait: begin
                  if (sw_si_clear) begin
                     bit_cnt_reg <= `CNT_ZERO;
                     if (tx_written_reg) begin
                        shift_reg <= tx_data_reg;
                        sda_oe <= !tx_data_reg[7];
                        tx_take_reg <= 1'b1;
                        state_reg <= smbus_slave_pkg::st_tx; // RL10
                     end else begin
                        state_reg <= smbus_slave_pkg::st_rx; // RL13
                     end
                  end
               end
               default: begin
                  state_reg <= smbus_slave_pkg::st_idle;
               end
            endcase
         end
      end
   end

   // =====================================================
   // Clock stretch and fixed pin drive values
   // =====================================================
   // Hold clock low only once it is already low
   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         scl_oe <= 1'b0;
         scl_out <= 1'b0;
         sda_out <= 1'b0;
      end else begin
         scl_oe <= !scl_s_reg && (
            state_reg == smbus_slave_pkg::st_wait ||
            state_reg == smbus_slave_pkg::st_txwait);
         scl_out <= 1'b0;
         sda_out <= 1'b0;
      end
   end

   // =====================================================
   // Configuration registers
   // =====================================================
   // Address, mask, hardware ACK and inhibit
   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         own_addr_reg <= `RST_OWN;
         gc_en_reg <= 1'b0;
         mask_reg <= `RST_MASK;
         hw_ack_reg <= 1'b0;
         inhibit_reg <= 1'b0;
         ack_out_reg <= 1'b0;
         int_mask_reg <= `RST_IRQ;
      end else if (wr_en) begin
         unique case (paddr)
            `OFF_ADDR: begin
               own_addr_reg <= pwdata[7:1];
               gc_en_reg <= pwdata[`LOW_BIT];
            end
            `OFF_MASK: begin
               mask_reg <= pwdata[7:1];
               hw_ack_reg <= pwdata[`LOW_BIT];
            end
            `OFF_CFG: inhibit_reg <= pwdata[`CFG_INH];
            `OFF_CTRL: ack_out_reg <= pwdata[`CTRL_ACK];
            `OFF_IMASK: int_mask_reg <= pwdata[2:0];
            default: begin
               // Other offsets hold no configuration
            end
         endcase
      end
   end

   // =====================================================
   // Transmit byte holding
   // =====================================================
   // Written flag: a new write wins over consumption
   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         tx_data_reg <= `RST_DATA;
         tx_written_reg <= 1'b0;
      end else if (wr_en && paddr == `OFF_DATA) begin
         tx_data_reg <= pwdata[7:0];
         tx_written_reg <= 1'b1;
      end else if (tx_take_reg || si_set_reg) begin
         tx_written_reg <= 1'b0;
      end
   end

   // =====================================================
   // Interrupt flag and status vector flags
   // =====================================================
   // Hardware set beats the software clear
   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         si_reg <= 1'b0;
         ack_request_flag_reg <= 1'b0;
         start_flag_reg <= 1'b0;
         stop_flag_reg <= 1'b0;
      end else begin
         si_reg <= si_set_reg || (si_reg && !sw_si_clear);
         ack_request_flag_reg <= ack_request_flag_set_reg || (ack_request_flag_reg && !sw_si_clear);
         start_flag_reg <= start_det ||
            (start_flag_reg && !sw_si_clear); // RL15
         stop_flag_reg <= stop_det ||
            (stop_flag_reg && !sw_si_clear); // RL15
      end
   end

   // =====================================================
   // Sticky events, mask and interrupt output
   // =====================================================
   always_comb begin
      events = `RST_IRQ;
      events[`EV_SI] = si_set_reg;
      events[`EV_STOP] = stop_det && state_reg !=
         smbus_slave_pkg::st_idle;
      // Data write after NACK while interrupt pending
      events[`EV_ERR] = wr_en && paddr == `OFF_DATA &&
         got_nack_reg && si_reg &&
         state_reg == smbus_slave_pkg::st_txwait; // RL11
   end

   // Write one clears; a same-cycle event survives
   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         int_stat_reg <= `RST_IRQ;
         irq <= 1'b0;
      end else begin
         if (wr_en && paddr == `OFF_ISTAT) begin
            int_stat_reg <= (int_stat_reg & ~pwdata[2:0]) | events;
         end else begin
            int_stat_reg <= int_stat_reg | events;
         end
         irq <= |(int_stat_reg & int_mask_reg);
      end
   end

   // =====================================================
   // APB read path and answer
   // =====================================================
   always_comb begin
      rd_mux = `ZERO32;
      addr_hit = 1'b1;
      unique case (paddr)
         `OFF_CTRL: begin
            // Master bit reads zero: slave-only block
            rd_mux[6] = tx_role; // RL15
            rd_mux[5] = start_flag_reg;
            rd_mux[4] = stop_flag_reg;
            rd_mux[`CTRL_ACK_REQUEST_FLAG] = ack_request_flag_reg;
            rd_mux[`CTRL_ACK] = ack_out_reg;
            rd_mux[`CTRL_SI] = si_reg;
         end
         `OFF_DATA: rd_mux[7:0] = rx_data_reg;
         `OFF_ADDR: rd_mux[7:0] = {own_addr_reg, gc_en_reg};
         `OFF_MASK: rd_mux[7:0] = {mask_reg, hw_ack_reg};
         `OFF_CFG: rd_mux[`CFG_INH] = inhibit_reg;
         `OFF_ISTAT: rd_mux[2:0] = int_stat_reg;
         `OFF_IMASK: rd_mux[2:0] = int_mask_reg;
         default: addr_hit = 1'b0;
      endcase
   end

   // One wait state; ready pulses for one cycle
   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         pready <= 1'b0;
         pslverr <= 1'b0;
         prdata <= `ZERO32;
      end else begin
         pready <= psel && penable && !pready;
         pslverr <= psel && penable && !pready && !addr_hit;
         if (rd_en) begin
            prdata <= rd_mux;
         end
      end
   end

endmodule // smbus_slave_addr_match

// ### verilog/smbus_slave_map.svh
// Function
// RL1 - hw_ack_enable: hardware address match and ACK
// RL2 - Mask bit one compares address bit
// RL3 - Mask bit zero makes bit don't-care
// RL4 - General call enable also accepts 0x00
// RL5 - Receive address, then transmit data bytes
// RL6 - Not inhibited: START plus address enters receiver
// RL7 - No hw ACK: interrupt, ack request, software answers
// RL8 - hw ACK: match acked, interrupt after ACK
// RL9 - Ignored address silences slave until START
// RL10 - Acked read: software loads data, device transmits
// RL11 - Data write after master NACK flags error
// RL12 - STOP ends transmitter mode
// RL13 - No data written: back to receiver mode
// RL14 - Transmit interrupts always after ACK cycle
// RL15 - Status vector: master, transmit, start, stop (master bit always reads zero here)
// RL16 - Compare seven bits; direction bit picks role
`ifndef SMBUS_SLAVE_MAP_SVH
`define SMBUS_SLAVE_MAP_SVH

// =====================================================
// Register byte offsets
// =====================================================
`define OFF_CTRL 8'h00
`define OFF_DATA 8'h04
`define OFF_ADDR 8'h08
`define OFF_MASK 8'h0C
`define OFF_CFG 8'h10
`define OFF_ISTAT 8'h14
`define OFF_IMASK 8'h18

// =====================================================
// Field positions
// =====================================================
`define CTRL_SI 0
`define CTRL_ACK 1
`define CTRL_ACK_REQUEST_FLAG 3
`define LOW_BIT 0
`define CFG_INH 0
`define EV_SI 0
`define EV_STOP 1
`define EV_ERR 2

// =====================================================
// Reset values and counts
// =====================================================
`define RST_OWN 7'h00
`define RST_MASK 7'h7F
`define RST_DATA 8'h00
`define RST_IRQ 3'h0
`define GC_ADDR 7'h00
`define CNT_ZERO 4'h0
`define CNT_ONE 4'h1
`define CNT_BYTE 4'h8
`define CNT_LAST 4'h7
`define ZERO32 32'h0000_0000

`endif

// ### verilog/smbus_slave_pkg.sv
package smbus_slave_pkg;
   // =====================================================
   // Slave engine states
   // =====================================================
   typedef enum logic [3:0] {
      st_idle = 4'h0, // Not addressed
      st_addr = 4'h1, // Shifting address byte
      st_wait = 4'h2, // Software decides ACK
      st_ack = 4'h3, // Driving ACK bit
      st_tx = 4'h4, // Shifting out data
      st_txack = 4'h5, // Sampling master ACK
      st_txwait = 4'h6, // Waiting for next byte
      st_rx = 4'h7, // Shifting in data
      st_ignore = 4'h8 // Silent until START
   } slave_state_e;
endpackage
